// [hw/sram_boundary_scan_tap.sv]
// Boundary-scan test port: controller, instruction, bypass, id and boundary registers.
`include "sram_tap_map.svh"
`default_nettype none
module sram_boundary_scan_tap
   import sram_tap_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic [`BSR_WIDTH-1:0] pinRing,
   output logic tdo,
   output logic tdoOe,
   output logic memOutHighZ,
   output logic [3:0] tapStateMon
);
   // The ring is sampled on the memory clock so capture sees settled levels.
   // Captured values of fast pins (the memory clock) stay unreliable.
   logic [`BSR_WIDTH-1:0] ringMeta_ff;
   logic [`BSR_WIDTH-1:0] ringSync_ff;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ringMeta_ff <= '0;
         ringSync_ff <= '0;
      end else begin
         ringMeta_ff <= pinRing;
         ringSync_ff <= ringMeta_ff;
      end
   end

   // Port reset follows the power-up reset only; memory logic is separate.
   logic tckRstMeta_ff;
   logic trstn;
   always_ff @(posedge tck or negedge resetn) begin
      if (!resetn) begin
         tckRstMeta_ff <= 1'b0;
         trstn <= 1'b0;
      end else begin
         tckRstMeta_ff <= 1'b1;
         trstn <= tckRstMeta_ff;
      end
   end

   typedef struct packed {
      tap_state_t st;
      logic [`IR_WIDTH-1:0] irShift;
      tap_op_t ir;
      logic bypass;
   } tap_st_t;
   tap_st_t state_ff;
   tap_st_t nxt_state;

   logic capDr;
   logic shDr;
   logic selBsr;
   logic [`ID_WIDTH-1:0] idVal;
   logic [`BSR_WIDTH-1:0] bsrVal;
   logic [`ID_WIDTH-1:0] idCode;
   assign idCode = {`ID_REVISION, `ID_DEPTH, `ID_WIDTH_FIELD, `ID_DEVICE,
                    `ID_VENDOR, `ID_PRESENT};
   assign capDr = (state_ff.st == ST_CAP_DR);
   assign shDr = (state_ff.st == ST_SHF_DR);
   assign selBsr = (state_ff.ir == OP_EXTEST) || (state_ff.ir == OP_SAMPLEZ)
                   || (state_ff.ir == OP_SAMPLE);

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff.st)
         ST_RESET: nxt_state.st = tms ? ST_RESET : ST_IDLE;
         ST_IDLE: nxt_state.st = tms ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: nxt_state.st = tms ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: nxt_state.st = tms ? ST_EX1_DR : ST_SHF_DR;
         ST_SHF_DR: nxt_state.st = tms ? ST_EX1_DR : ST_SHF_DR;
         ST_EX1_DR: nxt_state.st = tms ? ST_UPD_DR : ST_PAU_DR;
         ST_PAU_DR: nxt_state.st = tms ? ST_EX2_DR : ST_PAU_DR;
         ST_EX2_DR: nxt_state.st = tms ? ST_UPD_DR : ST_SHF_DR;
         ST_UPD_DR: nxt_state.st = tms ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR: nxt_state.st = tms ? ST_RESET : ST_CAP_IR;
         ST_CAP_IR: nxt_state.st = tms ? ST_EX1_IR : ST_SHF_IR;
         ST_SHF_IR: nxt_state.st = tms ? ST_EX1_IR : ST_SHF_IR;
         ST_EX1_IR: nxt_state.st = tms ? ST_UPD_IR : ST_PAU_IR;
         ST_PAU_IR: nxt_state.st = tms ? ST_EX2_IR : ST_PAU_IR;
         ST_EX2_IR: nxt_state.st = tms ? ST_UPD_IR : ST_SHF_IR;
         ST_UPD_IR: nxt_state.st = tms ? ST_SEL_DR : ST_IDLE;
      endcase
      // Any state reaches reset within five high edges.
      if (state_ff.st == ST_RESET) begin
         nxt_state.ir = OP_IDCODE;
      end
      if (state_ff.st == ST_CAP_IR) begin
         nxt_state.irShift = `IR_CAPTURE_PATTERN;
      end else if (state_ff.st == ST_SHF_IR) begin
         nxt_state.irShift = {tdi, state_ff.irShift[`IR_WIDTH-1:1]};
      end
      if (state_ff.st == ST_UPD_IR) begin
         nxt_state.ir = tap_op_t'(state_ff.irShift);
      end
      if (capDr && state_ff.ir == OP_BYPASS) begin
         nxt_state.bypass = 1'b0;
      end else if (shDr && state_ff.ir == OP_BYPASS) begin
         nxt_state.bypass = tdi;
      end
   end

   always_ff @(posedge tck or negedge trstn) begin
      if (!trstn) begin
         state_ff.st <= ST_RESET;
         state_ff.irShift <= '0;
         state_ff.ir <= OP_IDCODE;
         state_ff.bypass <= 1'b0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   tap_shift_reg #(
      .WIDTH(`ID_WIDTH)
   ) u_id (
      .tck(tck),
      .trstn(trstn),
      .capture(capDr && state_ff.ir == OP_IDCODE),
      .shift(shDr && state_ff.ir == OP_IDCODE),
      .tdiBit(tdi),
      .capData(idCode),
      .value(idVal)
   );

   // No preload: update-DR leaves the boundary register alone.
   tap_shift_reg #(
      .WIDTH(`BSR_WIDTH)
   ) u_bsr (
      .tck(tck),
      .trstn(trstn),
      .capture(capDr && selBsr),
      .shift(shDr && selBsr),
      .tdiBit(tdi),
      .capData(ringSync_ff),
      .value(bsrVal)
   );

   logic serialBit;
   always_comb begin
      serialBit = 1'b0;
      if (state_ff.st == ST_SHF_IR) begin
         serialBit = state_ff.irShift[0];
      end else if (state_ff.ir == OP_BYPASS) begin
         serialBit = state_ff.bypass;
      end else if (state_ff.ir == OP_IDCODE) begin
         serialBit = idVal[0];
      end else if (selBsr) begin
         serialBit = bsrVal[0];
      end
   end

   // Output stage on the falling edge.
   always_ff @(negedge tck or negedge trstn) begin
      if (!trstn) begin
         tdo <= 1'b0;
         tdoOe <= 1'b0;
      end else begin
         tdo <= serialBit;
         tdoOe <= (state_ff.st == ST_SHF_DR) || (state_ff.st == ST_SHF_IR);
      end
   end

   // Float decision is handed to the memory clock domain through two flops.
   logic floatReq;
   logic floatSync;
   logic floatReq_ff;
   always_ff @(posedge tck or negedge trstn) begin
      if (!trstn) begin
         floatReq_ff <= 1'b0;
      end else begin
         floatReq_ff <= (nxt_state.ir == OP_EXTEST) || (nxt_state.ir == OP_SAMPLEZ);
      end
   end
   assign floatReq = floatReq_ff;
   sync_two_ff u_float (
      .clk(clk),
      .resetn(resetn),
      .rstLevel(1'b0),
      .din(floatReq),
      .dout(floatSync)
   );
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         memOutHighZ <= 1'b0;
      end else begin
         memOutHighZ <= floatSync;
      end
   end

   always_ff @(posedge tck or negedge trstn) begin
      if (!trstn) begin
         tapStateMon <= 4'hF;
      end else begin
         tapStateMon <= nxt_state.st;
      end
   end

   // Checks.
   int unsigned hiCnt;
   always_ff @(posedge tck or negedge trstn) begin
      if (!trstn) begin
         hiCnt <= 0;
      end else begin
         hiCnt <= tms ? ((hiCnt < 5) ? hiCnt + 1 : hiCnt) : 0;
      end
   end
   property p_five_reset;
      @(posedge tck) disable iff (!trstn) (hiCnt >= 5) |-> (state_ff.st == ST_RESET);
   endproperty
   a_five_reset: assert property (p_five_reset) else $error("no reset after five");
   property p_capir;
      @(posedge tck) disable iff (!trstn)
         (state_ff.st == ST_CAP_IR) |=> (state_ff.irShift[1:0] == 2'h1);
   endproperty
   a_capir: assert property (p_capir) else $error("capture-IR pattern wrong");
   property p_ir_hold;
      @(posedge tck) disable iff (!trstn)
         (state_ff.st != ST_UPD_IR && state_ff.st != ST_RESET) |=> $stable(state_ff.ir);
   endproperty
   a_ir_hold: assert property (p_ir_hold) else $error("instruction changed early");
   property p_reset_id;
      @(posedge tck) disable iff (!trstn) (state_ff.st == ST_RESET) |=> (state_ff.ir == OP_IDCODE);
   endproperty
   a_reset_id: assert property (p_reset_id) else $error("reset lost id code");
   property p_oe;
      @(negedge tck) disable iff (!trstn)
         (state_ff.st == ST_IDLE) |=> !tdoOe;
   endproperty
   a_oe: assert property (p_oe) else $error("output driven outside shift");
   property p_bypass_clr;
      @(posedge tck) disable iff (!trstn)
         (capDr && state_ff.ir == OP_BYPASS) |=> !state_ff.bypass;
   endproperty
   a_bypass_clr: assert property (p_bypass_clr) else $error("bypass not cleared");
   sequence s_shf_ir;
      state_ff.st == ST_SHF_IR;
   endsequence
   property p_ir_shift;
      @(posedge tck) disable iff (!trstn)
         s_shf_ir |=> (state_ff.irShift[2] == $past(tdi));
   endproperty
   a_ir_shift: assert property (p_ir_shift) else $error("input not at top bit");
   property p_id_cap;
      @(posedge tck) disable iff (!trstn)
         (capDr && state_ff.ir == OP_IDCODE) |=> (idVal == idCode);
   endproperty
   a_id_cap: assert property (p_id_cap) else $error("id code not captured");
endmodule // sram_boundary_scan_tap
`default_nettype wire

// [hw/sram_tap_map.svh]
// Constants of the boundary-scan test port.
`ifndef SRAM_TAP_MAP_SVH
`define SRAM_TAP_MAP_SVH
`define IR_WIDTH 3
`define IR_CAPTURE_PATTERN 3'h1
`define ID_WIDTH 32
`define BSR_WIDTH 72
`define RESET_TMS_EDGES 5
`define ID_REVISION 4'h1
`define ID_DEPTH 5'h03
`define ID_WIDTH_FIELD 5'h04
`define ID_DEVICE 6'h05
`define ID_VENDOR 11'h2A5
`define ID_PRESENT 1'h1
`endif

// [hw/sram_tap_pkg.sv]
// Types of the boundary-scan test port.
`default_nettype none
package sram_tap_pkg;
   typedef enum logic [3:0] {
      ST_RESET = 4'hF, ST_IDLE = 4'hC, ST_SEL_DR = 4'h7, ST_CAP_DR = 4'h6,
      ST_SHF_DR = 4'h2, ST_EX1_DR = 4'h1, ST_PAU_DR = 4'h3, ST_EX2_DR = 4'h0,
      ST_UPD_DR = 4'h5, ST_SEL_IR = 4'h4, ST_CAP_IR = 4'hE, ST_SHF_IR = 4'hA,
      ST_EX1_IR = 4'h9, ST_PAU_IR = 4'hB, ST_EX2_IR = 4'h8, ST_UPD_IR = 4'hD
   } tap_state_t;
   typedef enum logic [2:0] {
      OP_EXTEST = 3'h0, OP_IDCODE = 3'h1, OP_SAMPLEZ = 3'h2, OP_RSVD3 = 3'h3,
      OP_SAMPLE = 3'h4, OP_RSVD5 = 3'h5, OP_RSVD6 = 3'h6, OP_BYPASS = 3'h7
   } tap_op_t;
endpackage
`default_nettype wire

// [hw/sync_two_ff.sv]
// Two-flop level synchroniser.
`default_nettype none
module sync_two_ff (
   input wire logic clk,
   input wire logic resetn,
   input wire logic rstLevel,
   input wire logic din,
   output logic dout
);
   typedef struct packed {
      logic meta;
      logic sync;
   } sync_st_t;
   sync_st_t state_ff;
   sync_st_t nxt_state;
   // Flops hold the level relative to rstLevel, so their reset value stays a constant.
   always_comb begin
      nxt_state.meta = din ^ rstLevel;
      nxt_state.sync = state_ff.meta;
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= 2'h0;
      end else begin
         state_ff <= nxt_state;
      end
   end
   assign dout = state_ff.sync ^ rstLevel;
endmodule // sync_two_ff
`default_nettype wire

// [hw/tap_shift_reg.sv]
// Shift register with parallel capture, shifting toward the low bit.
`default_nettype none
module tap_shift_reg #(
   parameter int WIDTH = 32
) (
   input wire logic tck,
   input wire logic trstn,
   input wire logic capture,
   input wire logic shift,
   input wire logic tdiBit,
   input wire logic [WIDTH-1:0] capData,
   output logic [WIDTH-1:0] value
);
   typedef struct packed {
      logic [WIDTH-1:0] data;
   } sr_st_t;
   sr_st_t state_ff;
   sr_st_t nxt_state;
   always_comb begin
      nxt_state = state_ff;
      if (capture) begin
         nxt_state.data = capData;
      end else if (shift) begin
         nxt_state.data = {tdiBit, state_ff.data[WIDTH-1:1]};
      end
   end
   always_ff @(posedge tck or negedge trstn) begin
      if (!trstn) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end
   assign value = state_ff.data;
endmodule // tap_shift_reg
`default_nettype wire

// [test/scan_ctrl_model.sv]
// Behavioural board scan controller that drives the test port.
`default_nettype none
module scan_ctrl_model (
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo,
   input wire logic tdoOe
);
   timeunit 1ns;
   timeprecision 100ps;
   // The test clock rests low between frames; unused lines idle high as if pulled up.
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end
   // One 125 ns period; the output is read midway through the low phase, 31 ns after the falling edge.
   task automatic step(input logic m, input logic d, output logic o, output logic oe);
      tms = m;
      tdi = d;
      #31;
      o = tdo;
      oe = tdoOe;
      #31.5 tck = 1'b1;
      #62.5 tck = 1'b0;
   endtask
   task automatic hold_reset(input int n);
      logic o;
      logic oe;
      repeat (n) step(1'b1, 1'b1, o, oe);
   endtask
   // Only defined instruction codes are ever handed to this task by the bench.
   task automatic scan(input logic ir, input int n, input logic [71:0] din,
                       output logic [71:0] dout, output logic oeOk);
      logic o;
      logic oe;
      dout = '0;
      step(1'b1, 1'b1, o, oe);
      if (ir) step(1'b1, 1'b1, o, oe);
      step(1'b0, 1'b1, o, oe);
      step(1'b0, 1'b1, o, oe);
      oeOk = ~oe;
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], o, oe);
         dout[i] = o;
         oeOk = oeOk & oe;
      end
      step(1'b1, 1'b1, o, oe);
      oeOk = oeOk & ~oe;
      step(1'b0, 1'b1, o, oe);
   endtask
endmodule // scan_ctrl_model
`default_nettype wire

// [test/test_sram_boundary_scan_tap.sv]
// Self-checking bench for the boundary-scan test port.
`include "sram_tap_map.svh"
`default_nettype none
module test_sram_boundary_scan_tap import sram_tap_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [71:0] RING = 72'h96_0F1E_2D3C_4B5A_6978;
   localparam logic [31:0] IDV = {`ID_REVISION, `ID_DEPTH, `ID_WIDTH_FIELD, `ID_DEVICE,
      `ID_VENDOR, `ID_PRESENT};
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [71:0] pinRing = '0;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo;
   logic tdoOe;
   logic memOutHighZ;
   logic [3:0] tapStateMon;
   int miscompares = 0;
   int cmpCount = 0;
   always #2 clk = ~clk;
   sram_boundary_scan_tap u_dut (.clk(clk), .resetn(resetn), .tck(tck), .tms(tms),
      .tdi(tdi), .pinRing(pinRing), .tdo(tdo), .tdoOe(tdoOe), .memOutHighZ(memOutHighZ),
      .tapStateMon(tapStateMon));
   scan_ctrl_model u_ctrl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe));
   task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", cmpCount, miscompares);
      if (miscompares == 0 && cmpCount > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic t_power_up();
      logic [71:0] d;
      logic ok;
      logic o;
      logic oe;
      chk(tapStateMon, ST_RESET);
      chk(tdoOe, 1'b0);
      chk(memOutHighZ, 1'b0);
      u_ctrl.step(1'b0, 1'b1, o, oe);
      chk(tapStateMon, ST_IDLE);
      // Two extra bits show serial input walking in at the top of the 32-bit register.
      u_ctrl.scan(1'b0, 34, 72'h2, d, ok);
      chk(d[31:0], IDV);
      chk(d[33:32], 2'b10);
      chk(ok, 1'b1);
   endtask
   task automatic t_bypass();
      logic [71:0] d;
      logic ok;
      u_ctrl.scan(1'b1, 3, 72'h7, d, ok);
      chk(d[1:0], 2'b01);
      chk(ok, 1'b1);
      u_ctrl.scan(1'b0, 4, 72'hB, d, ok);
      chk(d[3:0], 4'h6);
   endtask
   task automatic t_ring(input logic [2:0] code, input logic hz);
      logic [71:0] d;
      logic ok;
      @(posedge clk) pinRing <= RING ^ {69'h0, code};
      u_ctrl.scan(1'b1, 3, {69'h0, code}, d, ok);
      chk(memOutHighZ, hz);
      u_ctrl.scan(1'b0, 72, ~RING, d, ok);
      chk(d, RING ^ {69'h0, code});
      chk(ok, 1'b1);
   endtask
   task automatic t_reset_mid();
      logic [71:0] d;
      logic ok;
      logic o;
      logic oe;
      u_ctrl.scan(1'b1, 3, 72'h0, d, ok);
      u_ctrl.step(1'b1, 1'b1, o, oe);
      u_ctrl.step(1'b0, 1'b1, o, oe);
      u_ctrl.step(1'b0, 1'b1, o, oe);
      u_ctrl.hold_reset(4);
      chk(tapStateMon, ST_SEL_IR);
      u_ctrl.hold_reset(1);
      chk(tapStateMon, ST_RESET);
      // The identification code is reloaded on the first edge spent in reset.
      u_ctrl.hold_reset(1);
      chk(memOutHighZ, 1'b0);
      u_ctrl.step(1'b0, 1'b1, o, oe);
      u_ctrl.scan(1'b0, 32, '0, d, ok);
      chk(d[31:0], IDV);
   endtask
   initial begin
      #200000;
      miscompares++;
      close_out();
   end
   initial begin
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      u_ctrl.hold_reset(3);
      t_power_up();
      t_bypass();
      t_ring(3'h0, 1'b1);
      t_ring(3'h2, 1'b1);
      t_ring(3'h4, 1'b0);
      t_reset_mid();
      close_out();
   end
endmodule // test_sram_boundary_scan_tap
`default_nettype wire
